/* hdl/pin_mux_pkg.sv */
// constants and field layout for the pin function and source select block
package pin_mux_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PORT_A_SEL0 = 6'h13;
  localparam logic [5:0] IDX_PORT_B_SEL0 = 6'h15;
  localparam logic [5:0] IDX_PORT_B_SEL1 = 6'h16;
  localparam logic [5:0] IDX_MOD_SRC_SEL = 6'h18;
  localparam logic [5:0] IDX_STATUS = 6'h1f;
  // writable bits; reserved bits are never stored and read zero
  localparam logic [15:0] MASK_PORT_A_SEL0 = 16'h1f00;
  localparam logic [15:0] MASK_PORT_B_SEL0 = 16'h7ff5;
  localparam logic [15:0] MASK_PORT_B_SEL1 = 16'h0001;
  localparam logic [15:0] MASK_MOD_SRC_SEL = 16'h29f8;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // field positions
  localparam int A4_LSB = 8;
  localparam int A5_LSB = 10;
  localparam int A6_LSB = 12;
  localparam int B0_LSB = 0;
  localparam int B1_LSB = 2;
  localparam int B2_LSB = 4;
  localparam int B3_LSB = 6;
  localparam int B4_LSB = 8;
  localparam int B5_LSB = 11;
  localparam int B6_LSB = 13;
  localparam int B7_LSB = 0;
  localparam int MODULATOR_FAULT_IN1_BIT = 11;
  localparam int MODULATOR_FAULT_IN2_BIT = 13;
  localparam int PAIR1_LSB = 3;
  localparam int PAIR2_LSB = 6;
  // pin indices
  localparam int NPIN = 11;
  localparam int P_A4 = 0;
  localparam int P_A5 = 1;
  localparam int P_A6 = 2;
  localparam int P_B0 = 3;
  localparam int P_B1 = 4;
  localparam int P_B2 = 5;
  localparam int P_B3 = 6;
  localparam int P_B4 = 7;
  localparam int P_B5 = 8;
  localparam int P_B6 = 9;
  localparam int P_B7 = 10;
  // peripheral function indices
  localparam int NFN = 24;
  localparam int FN_W = 5;
  localparam logic [4:0] F_MODULATOR_FAULT_IN0 = 5'h00;
  localparam logic [4:0] F_MODULATOR_FAULT_IN1 = 5'h01;
  localparam logic [4:0] F_MODULATOR_FAULT_IN2 = 5'h02;
  localparam logic [4:0] F_MODULATOR_FAULT_IN3 = 5'h03;
  localparam logic [4:0] F_TA0 = 5'h04;
  localparam logic [4:0] F_TA1 = 5'h05;
  localparam logic [4:0] F_TA2 = 5'h06;
  localparam logic [4:0] F_TA3 = 5'h07;
  localparam logic [4:0] F_TB0 = 5'h08;
  localparam logic [4:0] F_PWM4 = 5'h09;
  localparam logic [4:0] F_PWM5 = 5'h0a;
  localparam logic [4:0] F_RXD = 5'h0b;
  localparam logic [4:0] F_TXD = 5'h0c;
  localparam logic [4:0] F_SDA = 5'h0d;
  localparam logic [4:0] F_SCL = 5'h0e;
  localparam logic [4:0] F_EXTERNAL_CLOCK_IN = 5'h0f;
  localparam logic [4:0] F_CLOCK_OUTPUT = 5'h10;
  localparam logic [4:0] F_MOSI = 5'h11;
  localparam logic [4:0] F_MISO = 5'h12;
  localparam logic [4:0] F_SS = 5'h13;
  localparam logic [4:0] F_SCLK = 5'h14;
  localparam logic [4:0] F_PAIR0_EXTERNAL_SOURCE = 5'h15;
  localparam logic [4:0] F_PAIR1_EXTERNAL_SOURCE = 5'h16;
  localparam logic [4:0] F_PAIR2_EXTERNAL_SOURCE = 5'h17;
  // pair source codes
  localparam logic [2:0] PS_PIN = 3'h0;
  localparam logic [2:0] PS_TIMER = 3'h1;
  localparam logic [2:0] PS_SAMPLE = 3'h2;
  localparam logic [2:0] PS_CMPA = 3'h3;
  localparam logic [2:0] PS_CMPB = 3'h4;
endpackage

/* hdl/pin_function_and_source_select.sv */
// pin function multiplexer and modulator input source selection with a wishbone register port
`timescale 1ns/1ps
module pin_function_and_source_select #(
  parameter int ADR_W = 8
) (
  // system
  input wire logic mclk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pads, indexed a4 a5 a6 b0..b7
  input wire logic [10:0] pad_in,
  output logic [10:0] pad_out,
  output logic [10:0] pad_oe,
  // general-purpose port side
  input wire logic [10:0] pin_peripheral_enable,
  input wire logic [10:0] gpio_out,
  input wire logic [10:0] gpio_oe,
  // peripheral functions
  input wire logic [23:0] fn_out,
  input wire logic [23:0] fn_oe,
  output logic [23:0] fn_in,
  // internal sources
  input wire logic comparator_a_out,
  input wire logic comparator_b_out,
  input wire logic sample1_high_limit,
  input wire logic sample1_low_limit,
  input wire logic sample2_high_limit,
  input wire logic sample2_low_limit,
  // modulator inputs
  output logic modulator_fault_in0,
  output logic modulator_fault_in1,
  output logic modulator_fault_in2,
  output logic modulator_fault_in3,
  output logic [2:0] pair_source,
  output logic [2:0] pair_force,
  output logic [2:0] pair_even_value,
  output logic [2:0] pair_odd_value
);

  typedef struct packed {
    logic [15:0] port_a_function_select_0;
    logic [15:0] port_b_function_select_0;
    logic [15:0] port_b_function_select_1;
    logic [15:0] modulator_input_source_select;
    logic ack;
    logic [15:0] rdata;
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] pad_out;
    logic [10:0] pad_oe;
    logic [23:0] fn_in;
    logic [3:0] fault;
    logic [2:0] psrc;
    logic [2:0] pforce;
    logic [2:0] peven;
    logic [2:0] podd;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [10:0][2:0] code;
  logic [10:0][4:0] map_fn;
  logic [10:0] map_ok;
  logic [10:0] hit;
  logic [10:0] pad_out_n;
  logic [10:0] pad_oe_n;
  logic [23:0][10:0] match;
  logic [23:0] fn_in_n;
  logic req;
  logic [5:0] idx;
  logic [15:0] wmask;
  logic [15:0] status;
  logic [2:0] p1_code;
  logic [2:0] p2_code;
  logic [1:0] p1_res;
  logic [1:0] p2_res;

  // field codes taken out of the select registers
  assign code[pin_mux_pkg::P_A4] =
    {1'b0, s_q.port_a_function_select_0[pin_mux_pkg::A4_LSB +: 2]};
  assign code[pin_mux_pkg::P_A5] =
    {1'b0, s_q.port_a_function_select_0[pin_mux_pkg::A5_LSB +: 2]};
  assign code[pin_mux_pkg::P_A6] =
    {2'b00, s_q.port_a_function_select_0[pin_mux_pkg::A6_LSB]};
  assign code[pin_mux_pkg::P_B0] =
    {2'b00, s_q.port_b_function_select_0[pin_mux_pkg::B0_LSB]};
  assign code[pin_mux_pkg::P_B1] =
    {2'b00, s_q.port_b_function_select_0[pin_mux_pkg::B1_LSB]};
  assign code[pin_mux_pkg::P_B2] =
    {1'b0, s_q.port_b_function_select_0[pin_mux_pkg::B2_LSB +: 2]};
  assign code[pin_mux_pkg::P_B3] =
    {1'b0, s_q.port_b_function_select_0[pin_mux_pkg::B3_LSB +: 2]};
  assign code[pin_mux_pkg::P_B4] =
    s_q.port_b_function_select_0[pin_mux_pkg::B4_LSB +: 3];
  assign code[pin_mux_pkg::P_B5] =
    {1'b0, s_q.port_b_function_select_0[pin_mux_pkg::B5_LSB +: 2]};
  assign code[pin_mux_pkg::P_B6] =
    {1'b0, s_q.port_b_function_select_0[pin_mux_pkg::B6_LSB +: 2]};
  assign code[pin_mux_pkg::P_B7] =
    {2'b00, s_q.port_b_function_select_1[pin_mux_pkg::B7_LSB]};

  // per-pin code to function lookup; reserved codes give no function
  always_comb begin
    map_ok = '1;
    map_fn = '0;
    for (int p = 0; p < pin_mux_pkg::NPIN; p++) begin
      unique case (p)
        pin_mux_pkg::P_A6: map_fn[p] = code[p][0] ? pin_mux_pkg::F_TA0
                                                   : pin_mux_pkg::F_MODULATOR_FAULT_IN0;
        pin_mux_pkg::P_A5, pin_mux_pkg::P_A4: begin
          unique case (code[p][1:0])
            2'h0: map_fn[p] = (p == pin_mux_pkg::P_A5) ? pin_mux_pkg::F_PWM5
                                                        : pin_mux_pkg::F_PWM4;
            2'h1: map_fn[p] = (p == pin_mux_pkg::P_A5) ? pin_mux_pkg::F_MODULATOR_FAULT_IN2
                                                        : pin_mux_pkg::F_MODULATOR_FAULT_IN1;
            2'h2: map_fn[p] = (p == pin_mux_pkg::P_A5) ? pin_mux_pkg::F_TA3
                                                        : pin_mux_pkg::F_TA2;
            default: map_ok[p] = 1'b0;
          endcase
        end
        pin_mux_pkg::P_B6: begin
          unique case (code[p][1:0])
            2'h0: map_fn[p] = pin_mux_pkg::F_RXD;
            2'h1: map_fn[p] = pin_mux_pkg::F_SDA;
            2'h2: map_fn[p] = pin_mux_pkg::F_EXTERNAL_CLOCK_IN;
            default: map_ok[p] = 1'b0;
          endcase
        end
        pin_mux_pkg::P_B5: begin
          unique case (code[p][1:0])
            2'h0: map_fn[p] = pin_mux_pkg::F_TA1;
            2'h1: map_fn[p] = pin_mux_pkg::F_MODULATOR_FAULT_IN3;
            2'h2: map_fn[p] = pin_mux_pkg::F_EXTERNAL_CLOCK_IN;
            default: map_ok[p] = 1'b0;
          endcase
        end
        pin_mux_pkg::P_B4: begin
          unique case (code[p])
            3'h0: map_fn[p] = pin_mux_pkg::F_TA0;
            3'h1: map_fn[p] = pin_mux_pkg::F_CLOCK_OUTPUT;
            3'h3: map_fn[p] = pin_mux_pkg::F_TB0;
            3'h4: map_fn[p] = pin_mux_pkg::F_PAIR2_EXTERNAL_SOURCE;
            default: map_ok[p] = 1'b0;
          endcase
        end
        pin_mux_pkg::P_B3: begin
          unique case (code[p][1:0])
            2'h0: map_fn[p] = pin_mux_pkg::F_MOSI;
            2'h1: map_fn[p] = pin_mux_pkg::F_TA3;
            2'h2: map_fn[p] = pin_mux_pkg::F_PAIR1_EXTERNAL_SOURCE;
            default: map_ok[p] = 1'b0;
          endcase
        end
        pin_mux_pkg::P_B2: begin
          unique case (code[p][1:0])
            2'h0: map_fn[p] = pin_mux_pkg::F_MISO;
            2'h1: map_fn[p] = pin_mux_pkg::F_TA2;
            2'h2: map_fn[p] = pin_mux_pkg::F_PAIR0_EXTERNAL_SOURCE;
            default: map_ok[p] = 1'b0;
          endcase
        end
        pin_mux_pkg::P_B1: map_fn[p] = code[p][0] ? pin_mux_pkg::F_SDA
                                                   : pin_mux_pkg::F_SS;
        pin_mux_pkg::P_B0: map_fn[p] = code[p][0] ? pin_mux_pkg::F_SCL
                                                   : pin_mux_pkg::F_SCLK;
        default: map_fn[p] = code[p][0] ? pin_mux_pkg::F_SCL
                                        : pin_mux_pkg::F_TXD;
      endcase
    end
  end

  // pad drive: general-purpose unless enabled, reserved codes leave the pad undriven
  genvar gp;
  genvar gf;
  generate
    for (gp = 0; gp < pin_mux_pkg::NPIN; gp++) begin : g_pin
      assign hit[gp] = pin_peripheral_enable[gp] & map_ok[gp];
      assign pad_out_n[gp] = !pin_peripheral_enable[gp] ? gpio_out[gp] :
                             (hit[gp] & fn_out[map_fn[gp]]);
      assign pad_oe_n[gp] = !pin_peripheral_enable[gp] ? gpio_oe[gp] :
                            (hit[gp] & fn_oe[map_fn[gp]]);
    end
    // input side: any selected pin may drive the function, ored together
    for (gf = 0; gf < pin_mux_pkg::NFN; gf++) begin : g_fn
      for (gp = 0; gp < pin_mux_pkg::NPIN; gp++) begin : g_match
        assign match[gf][gp] = hit[gp] && (map_fn[gp] == 5'(gf));
      end
      assign fn_in_n[gf] = |(match[gf] & s_q.sync2);
    end
  endgenerate

  // pair source codes; codes above four are reserved
  assign p1_code = s_q.modulator_input_source_select[pin_mux_pkg::PAIR1_LSB +: 3];
  assign p2_code = s_q.modulator_input_source_select[pin_mux_pkg::PAIR2_LSB +: 3];
  assign p1_res = {p1_code > pin_mux_pkg::PS_CMPB, 1'b0};
  assign p2_res = {p2_code > pin_mux_pkg::PS_CMPB, p2_code == pin_mux_pkg::PS_PIN};

  // bus decode
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[7:2];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign status = {3'b000, p1_res[1], |p2_res, ~map_ok};

  // next state: register writes, read data, resynchronised pads and outputs
  always_comb begin
    s_d = s_q;
    s_d.sync1 = pad_in;
    s_d.sync2 = s_q.sync1;
    s_d.ack = req & !s_q.ack;
    s_d.rdata = 16'h0000;
    if (req & !s_q.ack) begin
      unique case (idx)
        pin_mux_pkg::IDX_PORT_A_SEL0: s_d.rdata = s_q.port_a_function_select_0;
        pin_mux_pkg::IDX_PORT_B_SEL0: s_d.rdata = s_q.port_b_function_select_0;
        pin_mux_pkg::IDX_PORT_B_SEL1: s_d.rdata = s_q.port_b_function_select_1;
        pin_mux_pkg::IDX_MOD_SRC_SEL: s_d.rdata = s_q.modulator_input_source_select;
        pin_mux_pkg::IDX_STATUS: s_d.rdata = status;
        default: s_d.rdata = 16'h0000; // unmapped reads zero
      endcase
    end
    // only defined field bits store; reserved writes are dropped
    if (req & !s_q.ack & wb_we_i) begin
      unique case (idx)
        pin_mux_pkg::IDX_PORT_A_SEL0: s_d.port_a_function_select_0 =
          (s_q.port_a_function_select_0 & ~(wmask & pin_mux_pkg::MASK_PORT_A_SEL0)) |
          (wb_dat_i[15:0] & wmask & pin_mux_pkg::MASK_PORT_A_SEL0);
        pin_mux_pkg::IDX_PORT_B_SEL0: s_d.port_b_function_select_0 =
          (s_q.port_b_function_select_0 & ~(wmask & pin_mux_pkg::MASK_PORT_B_SEL0)) |
          (wb_dat_i[15:0] & wmask & pin_mux_pkg::MASK_PORT_B_SEL0);
        pin_mux_pkg::IDX_PORT_B_SEL1: s_d.port_b_function_select_1 =
          (s_q.port_b_function_select_1 & ~(wmask & pin_mux_pkg::MASK_PORT_B_SEL1)) |
          (wb_dat_i[15:0] & wmask & pin_mux_pkg::MASK_PORT_B_SEL1);
        pin_mux_pkg::IDX_MOD_SRC_SEL: s_d.modulator_input_source_select =
          (s_q.modulator_input_source_select & ~(wmask & pin_mux_pkg::MASK_MOD_SRC_SEL)) |
          (wb_dat_i[15:0] & wmask & pin_mux_pkg::MASK_MOD_SRC_SEL);
        default: s_d.ack = s_d.ack; // ignored, still acknowledged
      endcase
    end
    s_d.pad_out = pad_out_n;
    s_d.pad_oe = pad_oe_n;
    s_d.fn_in = fn_in_n;
    // fault inputs; pin path relies on software routing one enabled pin
    s_d.fault[0] = fn_in_n[pin_mux_pkg::F_MODULATOR_FAULT_IN0];
    s_d.fault[1] = s_q.modulator_input_source_select[pin_mux_pkg::MODULATOR_FAULT_IN1_BIT] ?
                   comparator_a_out : fn_in_n[pin_mux_pkg::F_MODULATOR_FAULT_IN1];
    s_d.fault[2] = s_q.modulator_input_source_select[pin_mux_pkg::MODULATOR_FAULT_IN2_BIT] ?
                   comparator_b_out : fn_in_n[pin_mux_pkg::F_MODULATOR_FAULT_IN2];
    s_d.fault[3] = fn_in_n[pin_mux_pkg::F_MODULATOR_FAULT_IN3];
    // pair 0 has only its pin source here
    s_d.psrc[0] = fn_in_n[pin_mux_pkg::F_PAIR0_EXTERNAL_SOURCE];
    s_d.pforce[0] = 1'b0;
    s_d.peven[0] = 1'b0;
    s_d.podd[0] = 1'b0;
    // pair 1
    s_d.pforce[1] = 1'b0;
    s_d.peven[1] = 1'b0;
    s_d.podd[1] = 1'b0;
    unique case (p1_code)
      pin_mux_pkg::PS_PIN: s_d.psrc[1] = fn_in_n[pin_mux_pkg::F_PAIR1_EXTERNAL_SOURCE];
      pin_mux_pkg::PS_TIMER: s_d.psrc[1] = fn_out[pin_mux_pkg::F_TA2];
      pin_mux_pkg::PS_SAMPLE: begin
        s_d.psrc[1] = 1'b0;
        s_d.pforce[1] = sample1_high_limit | sample1_low_limit;
        s_d.peven[1] = !sample1_high_limit & sample1_low_limit;
        s_d.podd[1] = sample1_high_limit;
      end
      pin_mux_pkg::PS_CMPA: s_d.psrc[1] = comparator_a_out;
      pin_mux_pkg::PS_CMPB: s_d.psrc[1] = comparator_b_out;
      default: s_d.psrc[1] = 1'b0;
    endcase
    // pair 2; code zero is reserved here
    s_d.pforce[2] = 1'b0;
    s_d.peven[2] = 1'b0;
    s_d.podd[2] = 1'b0;
    unique case (p2_code)
      pin_mux_pkg::PS_TIMER: s_d.psrc[2] = fn_out[pin_mux_pkg::F_TA3];
      pin_mux_pkg::PS_SAMPLE: begin
        s_d.psrc[2] = 1'b0;
        s_d.pforce[2] = sample2_high_limit | sample2_low_limit;
        s_d.peven[2] = !sample2_high_limit & sample2_low_limit;
        s_d.podd[2] = sample2_high_limit;
      end
      pin_mux_pkg::PS_CMPA: s_d.psrc[2] = comparator_a_out;
      pin_mux_pkg::PS_CMPB: s_d.psrc[2] = comparator_b_out;
      default: s_d.psrc[2] = 1'b0;
    endcase
  end

  // state register; select fields reset to their default codes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.port_a_function_select_0 <= pin_mux_pkg::REG_RESET;
      s_q.port_b_function_select_0 <= pin_mux_pkg::REG_RESET;
      s_q.port_b_function_select_1 <= pin_mux_pkg::REG_RESET;
      s_q.modulator_input_source_select <= pin_mux_pkg::REG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {16'h0000, s_q.rdata};
  assign pad_out = s_q.pad_out;
  assign pad_oe = s_q.pad_oe;
  assign fn_in = s_q.fn_in;
  assign modulator_fault_in0 = s_q.fault[0];
  assign modulator_fault_in1 = s_q.fault[1];
  assign modulator_fault_in2 = s_q.fault[2];
  assign modulator_fault_in3 = s_q.fault[3];
  assign pair_source = s_q.psrc;
  assign pair_force = s_q.pforce;
  assign pair_even_value = s_q.peven;
  assign pair_odd_value = s_q.podd;

  // checks
  sequence s_new_req;
    req && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_once: assert property (@(posedge mclk) disable iff (!rst_n)
    s_new_req |=> s_ack_pulse) else $error("ack not a single pulse");
  a_gpio_pad_path: assert property (@(posedge mclk) disable iff (!rst_n)
    !pin_peripheral_enable[pin_mux_pkg::P_B0] |=> pad_out[pin_mux_pkg::P_B0] ==
    $past(gpio_out[pin_mux_pkg::P_B0])) else $error("gpio pad path wrong");
  a_a6_timer_out: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_peripheral_enable[pin_mux_pkg::P_A6] && code[pin_mux_pkg::P_A6] == 3'h1
    |=> pad_out[pin_mux_pkg::P_A6] == $past(fn_out[pin_mux_pkg::F_TA0]))
    else $error("a6 timer route wrong");
  a_a4_reserved_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_peripheral_enable[pin_mux_pkg::P_A4] && code[pin_mux_pkg::P_A4] == 3'h3
    |=> !pad_oe[pin_mux_pkg::P_A4] && !pad_out[pin_mux_pkg::P_A4])
    else $error("reserved code drives pad");
  a_modulator_fault_in1_comp: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.modulator_input_source_select[pin_mux_pkg::MODULATOR_FAULT_IN1_BIT] |=>
    modulator_fault_in1 == $past(comparator_a_out)) else $error("modulator_fault_in1 source wrong");
  a_modulator_fault_in2_comp: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.modulator_input_source_select[pin_mux_pkg::MODULATOR_FAULT_IN2_BIT] |=>
    modulator_fault_in2 == $past(comparator_b_out)) else $error("modulator_fault_in2 source wrong");
  a_pair_high_limit: assert property (@(posedge mclk) disable iff (!rst_n)
    p1_code == pin_mux_pkg::PS_SAMPLE && sample1_high_limit |=>
    pair_force[1] && !pair_even_value[1] && pair_odd_value[1])
    else $error("high limit force wrong");
  a_pair_low_limit: assert property (@(posedge mclk) disable iff (!rst_n)
    p2_code == pin_mux_pkg::PS_SAMPLE && sample2_low_limit && !sample2_high_limit
    |=> pair_force[2] && pair_even_value[2] && !pair_odd_value[2])
    else $error("low limit force wrong");
  a_write_stores: assert property (@(posedge mclk) disable iff (!rst_n)
    s_new_req and (wb_we_i && idx == pin_mux_pkg::IDX_PORT_A_SEL0 && wb_sel_i[1])
    |=> s_q.port_a_function_select_0[11:10] == $past(wb_dat_i[11:10]))
    else $error("field write lost");

endmodule

/* bench/periph_pad_model.sv */
// pad-side model: board pin levels meeting the block's own drive
`timescale 1ns/1ps
module periph_pad_model (
  // drive from the block
  input wire logic [10:0] pad_out,
  input wire logic [10:0] pad_oe,
  // level the board puts on an undriven pin; zero acts as a pull-down
  input wire logic [10:0] ext_level,
  // level seen back at the pin
  output logic [10:0] pad_in
);
  // a driven pin reads back its drive, a released one never keeps a stale value
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

/* bench/tb_top.sv */
// self-checking bench for the pin function and source select block
`timescale 1ns/1ps
module tb_top;
  localparam logic [5:0] RA = pin_mux_pkg::IDX_PORT_A_SEL0;
  localparam logic [5:0] RB = pin_mux_pkg::IDX_PORT_B_SEL0;
  localparam logic [5:0] R1 = pin_mux_pkg::IDX_PORT_B_SEL1;
  localparam logic [5:0] RS = pin_mux_pkg::IDX_MOD_SRC_SEL;
  logic mclk, rst_n, cyc, stb, we, ca, cb, h1, l1, h2, l2;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat;
  logic [10:0] pen, gout, goe, ext;
  logic [23:0] fo, foe;
  logic [15:0] q;
  wire logic [31:0] rdat;
  wire logic ack, f0, f1, f2, f3;
  wire logic [10:0] pin, pout, poe;
  wire logic [23:0] fin;
  wire logic [2:0] ps, pf, pev, pod;
  int num_errors, checks_done;
  pin_function_and_source_select dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in(pin), .pad_out(pout), .pad_oe(poe),
    .pin_peripheral_enable(pen), .gpio_out(gout), .gpio_oe(goe), .fn_out(fo), .fn_oe(foe),
    .fn_in(fin), .comparator_a_out(ca), .comparator_b_out(cb), .sample1_high_limit(h1),
    .sample1_low_limit(l1), .sample2_high_limit(h2), .sample2_low_limit(l2),
    .modulator_fault_in0(f0), .modulator_fault_in1(f1), .modulator_fault_in2(f2),
    .modulator_fault_in3(f3), .pair_source(ps), .pair_force(pf), .pair_even_value(pev),
    .pair_odd_value(pod));
  periph_pad_model pads (.pad_out(pout), .pad_oe(poe), .ext_level(ext), .pad_in(pin));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle; waits up to 20 edges for ack, ack and read data taken at one rising edge
  task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    sel <= 4'h3;
    dat <= {16'h0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat[15:0];
    if (n >= 20) num_errors++;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  // two sync stages plus output register, with a cycle of margin
  task automatic settle;
    repeat (5) @(negedge mclk);
  endtask
  task automatic pin_out(input int p, input logic [5:0] i, input logic [15:0] v, input int f);
    wb(1'h1, i, v);
    pen <= 11'h001 << p;
    fo <= 24'h00_0001 << f;
    foe <= 24'hff_ffff;
    settle;
    chk("pad drive", {poe[p], pout[p]}, 16'h0003);
    @(posedge mclk);
    fo <= ~(24'h00_0001 << f);
    settle;
    chk("pad drive", {poe[p], pout[p]}, 16'h0002);
  endtask
  task automatic pin_in(input int p, input logic [5:0] i, input logic [15:0] v, input int f);
    wb(1'h1, i, v);
    pen <= 11'h001 << p; // only this pin enabled
    foe <= 24'h00_0000;
    ext <= 11'h001 << p;
    settle;
    chk("fn input", fin[f], 16'h0001);
    chk("fn routes", {f3, f2, f1, f0, ps}, {9'h000, (f < 4) ? 4'(1 << f) : 4'h0,
      (f == 21 || f == 22) ? 3'(1 << (f - 21)) : 3'h0});
    @(posedge mclk);
    ext <= ~(11'h001 << p);
    settle;
    chk("fn input", fin[f], 16'h0000);
    chk("fn routes", {f3, f2, f1, f0, ps}, 16'h0000);
  endtask
  // drive the pair sources from the mask, bit order timer, cmp a, cmp b
  task automatic src(input int p, input logic [2:0] m);
    @(posedge mclk);
    fo <= m[0] ? (24'h00_0001 << (5 + p)) : 24'h00_0000;
    ca <= m[1];
    cb <= m[2];
    settle;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(100 * 8000);
    num_errors++;
    end_of_test;
  end
  initial begin
    logic [5:0] ri [4];
    logic [15:0] rm [4];
    int ks [3];
    ri = '{RA, RB, R1, RS};
    rm = '{pin_mux_pkg::MASK_PORT_A_SEL0, pin_mux_pkg::MASK_PORT_B_SEL0,
      pin_mux_pkg::MASK_PORT_B_SEL1, pin_mux_pkg::MASK_MOD_SRC_SEL};
    ks = '{1, 3, 4};
    {rst_n, cyc, stb, we, ca, cb, h1, l1, h2, l2} = '0;
    {adr, sel, dat, pen, gout, goe, ext, fo, foe} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      wb(1'h0, ri[k], 16'h0000);
      chk("reset value", q, 16'h0000);
      wb(1'h1, ri[k], 16'hffff);
      wb(1'h0, ri[k], 16'h0000);
      chk("reserved bits", q, rm[k]);
      wb(1'h1, ri[k], 16'h0000);
    end
    wb(1'h1, 6'h20, 16'hffff);
    wb(1'h0, 6'h20, 16'h0000);
    chk("unmapped", q, 16'h0000);
    @(posedge mclk);
    gout <= 11'h5a5;
    goe <= 11'h0f0;
    fo <= 24'hff_ffff;
    foe <= 24'hff_ffff;
    settle;
    chk("gpio out", pout, 16'h05a5);
    chk("gpio oe", poe, 16'h00f0);
    pin_out(2, RA, 16'h1000, 4);
    pin_out(1, RA, 16'h0000, 10);
    pin_out(0, RA, 16'h0200, 6);
    pin_out(9, RB, 16'h2000, 13);
    pin_out(8, RB, 16'h0000, 5);
    pin_out(7, RB, 16'h0100, 16);
    pin_out(7, RB, 16'h0300, 8);
    pin_out(6, RB, 16'h0040, 7);
    pin_out(5, RB, 16'h0010, 6);
    pin_out(4, RB, 16'h0004, 13);
    pin_out(3, RB, 16'h0000, 20);
    pin_out(10, R1, 16'h0000, 12);
    pin_in(2, RA, 16'h0000, 0);
    pin_in(1, RA, 16'h0400, 2);
    pin_in(0, RA, 16'h0100, 1);
    pin_in(9, RB, 16'h0000, 11);
    pin_in(9, RB, 16'h4000, 15);
    pin_in(8, RB, 16'h0800, 3);
    pin_in(7, RB, 16'h0400, 23);
    pin_in(6, RB, 16'h0080, 22);
    pin_in(5, RB, 16'h0020, 21);
    pin_in(4, RB, 16'h0000, 19);
    wb(1'h1, RA, 16'h0300);
    pen <= 11'h001;
    @(posedge mclk);
    fo <= 24'hff_ffff;
    foe <= 24'hff_ffff;
    settle;
    chk("reserved code", {poe[0], pout[0]}, 16'h0000);
    wb(1'h0, pin_mux_pkg::IDX_STATUS, 16'h0000);
    chk("status", q, 16'h0801);
    wb(1'h1, RA, 16'h0000);
    wb(1'h1, RB, 16'h0001);
    wb(1'h1, R1, 16'h0001);
    pen <= 11'h408;
    fo <= 24'h00_4000;
    settle;
    chk("fan out", {pout[10], pout[3]}, 16'h0003);
    @(posedge mclk);
    foe <= 24'h00_0000;
    ext <= 11'h008;
    settle;
    chk("combined in", fin[14], 16'h0001);
    wb(1'h1, RS, 16'h2800); // fault 1 from comparator a, fault 2 from comparator b
    src(1, 3'h2);
    chk("fault src", {f2, f1}, 16'h0001);
    src(1, 3'h4);
    chk("fault src", {f2, f1}, 16'h0002);
    for (int p = 1; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        wb(1'h1, RS, 16'(ks[k]) << (3 * p));
        src(p, 3'h1 << k);
        chk("pair src", ps[p], 16'h0001);
        src(p, ~(3'h1 << k));
        chk("pair src", ps[p], 16'h0000);
      end
      wb(1'h1, RS, 16'h0002 << (3 * p));
      h1 <= (p == 1);
      h2 <= (p == 2);
      settle;
      chk("above limit", {pf[p], pev[p], pod[p]}, 16'h0005);
      @(posedge mclk);
      {h1, h2} <= 2'h0;
      l1 <= (p == 1);
      l2 <= (p == 2);
      settle;
      chk("below limit", {pf[p], pev[p], pod[p]}, 16'h0006);
    end
    wb(1'h1, RS, 16'h0000);
    src(2, 3'h7);
    chk("pair2 reserved", ps[2], 16'h0000);
    end_of_test;
  end
endmodule
